// ===== tscs_cfg.svh
`ifndef TSCS_CFG_SVH
`define TSCS_CFG_SVH

// ==========================================
// Register offsets
`define TSCS_OFS_MODE 8'h00
`define TSCS_OFS_CMD 8'h04
`define TSCS_OFS_STAT 8'h08
`define TSCS_OFS_CFG 8'h0c

// ==========================================
// Mode register fields
`define TSCS_MODE_REN 0
`define TSCS_MODE_TEN 1
`define TSCS_MODE_DM 2
`define TSCS_MODE_SM 4
`define TSCS_MODE_REVERSE_BIT_ORDER 8
`define TSCS_MODE_CHAR_LENGTH_FIELD 11
`define TSCS_MODE_RST 16'h0000
`define TSCS_MODE_WMASK 16'h793f
`define TSCS_SM_TRANSPARENT 2'h3

// ==========================================
// Command bits
`define TSCS_CMD_STOP 0
`define TSCS_CMD_RESTART 1
`define TSCS_CMD_INIT_TX 2
`define TSCS_CMD_INIT_RX 3
`define TSCS_CMD_HUNT 4
`define TSCS_CMD_CLOSE_RX 5

// ==========================================
// Status and configuration fields
`define TSCS_STAT_TX_SYNC 0
`define TSCS_STAT_RX_SYNC 1
`define TSCS_STAT_STOPPED 2
`define TSCS_STAT_UNDERRUN 3
`define TSCS_STAT_RX_BUSY 4
`define TSCS_STAT_TX_PTR 8
`define TSCS_STAT_RX_PTR 16
`define TSCS_CFG_TSA 0

// ==========================================
// Transmit FIFO
`define TSCS_TX_FIFO_DEPTH 2
`define TSCS_TX_FIFO_W 17
`define TSCS_TX_FIFO_CW 2
`define TSCS_ONES 16'hffff

`endif

// ===== tscs_pkg.sv
package tscs_pkg;

	typedef enum logic [2:0] {
		TX_OFF,
		TX_HUNT,
		TX_IDLE,
		TX_DATA,
		TX_HELD
	} tscs_tx_state_t;

	typedef enum logic [1:0] {
		RX_OFF,
		RX_HUNT,
		RX_ON
	} tscs_rx_state_t;

endpackage : tscs_pkg

// ===== tscs_fifo_if.sv
`timescale 1ns/100ps
interface tscs_fifo_if #(
	parameter int W = 17,
	parameter int CW = 2
);
	logic push;
	logic pop;
	logic flush;
	logic [W-1:0] wdata;
	logic [W-1:0] rdata;
	logic valid;
	logic [CW-1:0] count;

	modport ctrl(output push, output pop, output flush, output wdata,
		input rdata, input valid, input count);
	modport mem(input push, input pop, input flush, input wdata,
		output rdata, output valid, output count);
endinterface : tscs_fifo_if

// ===== tscs_txfifo.sv
`timescale 1ns/100ps
module tscs_txfifo #(
	parameter int W = 17,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic rstn,
	tscs_fifo_if.mem bus
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("tscs_txfifo depth must be a power of two, at least two");
	end

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic [W-1:0] rdata;
		logic valid;
	} tscs_fifo_state_t;

	tscs_fifo_state_t q;
	tscs_fifo_state_t d;

	// ==========================================
	// Pointer and storage update
	always_comb begin
		d = q;
		if (bus.push && q.cnt != DEPTH[AW:0]) begin
			d.mem[q.wp] = bus.wdata;
			d.wp = AW'(q.wp + 1'b1);
			d.cnt = (AW + 1)'(d.cnt + 1'b1);
		end
		if (bus.pop && q.cnt != '0) begin
			d.rp = AW'(q.rp + 1'b1);
			d.cnt = (AW + 1)'(d.cnt - 1'b1);
		end
		if (bus.flush) begin
			d.wp = '0;
			d.rp = '0;
			d.cnt = '0;
		end
		// Registered read port
		d.rdata = q.mem[q.rp];
		d.valid = (q.cnt != '0) && !bus.flush;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign bus.rdata = q.rdata;
	assign bus.valid = q.valid;
	assign bus.count = q.cnt;
endmodule : tscs_txfifo

// ===== tscs_top.sv
`timescale 1ns/100ps
`include "tscs_cfg.svh"
module tscs_top #(
	parameter logic [7:0] NUM_BD = 8'h08
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic serial_bit_clock,
	input wire logic ext_sync_pin,
	input wire logic frame_sync,
	input wire logic tx_slot,
	input wire logic rx_slot,
	input wire logic rxd,
	output logic txd,
	input wire logic tx_char_valid,
	input wire logic [15:0] tx_char_data,
	input wire logic tx_char_last,
	output logic tx_char_ready,
	output logic tx_error_event,
	output logic tx_underrun_flag,
	output logic [7:0] tx_descriptor_pointer,
	output logic rx_char_valid,
	output logic [15:0] rx_char_data,
	input wire logic rx_char_ready,
	output logic rx_buf_close,
	output logic rx_buf_overrun,
	output logic [7:0] rx_descriptor_pointer
);
	if (NUM_BD == 8'h00) begin : g_bad_bd
		$error("tscs_top needs at least one descriptor");
	end

	// Synchroniser lanes
	localparam int SY_SCLK = 0;
	localparam int SY_SYNC = 1;
	localparam int SY_FS = 2;
	localparam int SY_TXS = 3;
	localparam int SY_RXS = 4;
	localparam int SY_RXD = 5;

	typedef struct packed {
		logic [15:0] mode;
		logic time_slot_assigner;
		logic [31:0] rdata;
		logic [5:0] sync1;
		logic [5:0] sync2;
		logic sclk_p;
		logic tx_slot_p;
		logic rx_slot_p;
		logic tx_fs;
		logic rx_fs;
		tscs_pkg::tscs_tx_state_t tx_st;
		logic [3:0] tx_bit;
		logic [15:0] tx_char;
		logic tx_last;
		logic tx_stop;
		logic txd;
		logic tx_ready;
		logic tx_err;
		logic tx_un;
		logic [7:0] tx_ptr;
		tscs_pkg::tscs_rx_state_t rx_st;
		logic [3:0] rx_bit;
		logic [15:0] rx_acc;
		logic [15:0] rx_hold;
		logic rx_full;
		logic rx_busy;
		logic rx_close;
		logic rx_ov;
		logic [7:0] rx_ptr;
	} tscs_state_t;

	tscs_state_t q;
	tscs_state_t d;

	tscs_fifo_if #(.W(`TSCS_TX_FIFO_W), .CW(`TSCS_TX_FIFO_CW)) fifo_bus();

	tscs_txfifo #(.W(`TSCS_TX_FIFO_W), .DEPTH(`TSCS_TX_FIFO_DEPTH)) u_txfifo (
		.clk(clk),
		.rstn(rstn),
		.bus(fifo_bus.mem)
	);

	// ==========================================
	// Helpers
	function automatic logic [3:0] bit_pos(input logic [3:0] idx, input logic [3:0] len,
		input logic rev);
		bit_pos = rev ? 4'(len - idx) : idx;
	endfunction : bit_pos

	function automatic logic [15:0] char_mask(input logic [3:0] len);
		char_mask = `TSCS_ONES >> 4'(4'hf - len);
	endfunction : char_mask

	function automatic logic [7:0] ptr_next(input logic [7:0] p);
		ptr_next = (p == 8'(NUM_BD - 8'h01)) ? 8'h00 : 8'(p + 8'h01);
	endfunction : ptr_next

	logic [3:0] char_length_field;
	logic reverse_bit_order;
	logic chan_on;
	logic ten_on;
	logic ren_on;
	logic rise;
	logic fall;
	logic cmd_wr;
	logic c_stop;
	logic c_restart;
	logic c_init_tx;
	logic c_init_rx;
	logic c_hunt;
	logic c_close;
	logic push;
	logic pop;
	logic rx_pop;
	logic [2:0] cnt_next;

	assign char_length_field = q.mode[`TSCS_MODE_CHAR_LENGTH_FIELD +: 4];
	assign reverse_bit_order = q.mode[`TSCS_MODE_REVERSE_BIT_ORDER];
	assign chan_on = q.mode[`TSCS_MODE_SM +: 2] == `TSCS_SM_TRANSPARENT;
	assign ten_on = chan_on && q.mode[`TSCS_MODE_TEN];
	assign ren_on = chan_on && q.mode[`TSCS_MODE_REN];
	assign rise = q.sync2[SY_SCLK] && !q.sclk_p;
	assign fall = !q.sync2[SY_SCLK] && q.sclk_p;
	assign cmd_wr = reg_wr && reg_addr == `TSCS_OFS_CMD;
	assign c_stop = cmd_wr && reg_wdata[`TSCS_CMD_STOP];
	assign c_restart = cmd_wr && reg_wdata[`TSCS_CMD_RESTART];
	assign c_init_tx = cmd_wr && reg_wdata[`TSCS_CMD_INIT_TX];
	assign c_init_rx = cmd_wr && reg_wdata[`TSCS_CMD_INIT_RX];
	assign c_hunt = cmd_wr && reg_wdata[`TSCS_CMD_HUNT];
	assign c_close = cmd_wr && reg_wdata[`TSCS_CMD_CLOSE_RX];
	assign push = tx_char_valid && q.tx_ready;
	assign rx_pop = q.rx_full && rx_char_ready;
	assign fifo_bus.push = push;
	assign fifo_bus.pop = pop;
	assign fifo_bus.flush = !ten_on;
	assign fifo_bus.wdata = {tx_char_last, tx_char_data};

	// ==========================================
	// Next state
	always_comb begin
		logic [15:0] cur;
		logic [3:0] nb;
		logic [31:0] rd;
		logic [15:0] acc;
		tscs_pkg::tscs_tx_state_t st_now;
		logic started;
		logic cap;
		cur = q.tx_char;
		nb = q.tx_bit;
		rd = 32'h0;
		acc = q.rx_acc;
		st_now = q.tx_st;
		started = 1'b0;
		cap = 1'b0;
		pop = 1'b0;
		d = q;
		d.tx_err = 1'b0;
		d.rx_close = 1'b0;
		d.rx_ov = 1'b0;
		d.sync1 = {rxd, rx_slot, tx_slot, frame_sync, ext_sync_pin, serial_bit_clock};
		d.sync2 = q.sync1;
		d.sclk_p = q.sync2[SY_SCLK];

		// Register port
		if (reg_wr && reg_addr == `TSCS_OFS_MODE) begin
			d.mode = reg_wdata[15:0] & `TSCS_MODE_WMASK;
		end
		if (reg_wr && reg_addr == `TSCS_OFS_CFG) begin
			d.time_slot_assigner = reg_wdata[`TSCS_CFG_TSA];
		end
		if (reg_rd) begin
			case (reg_addr)
				`TSCS_OFS_MODE: rd[15:0] = q.mode;
				`TSCS_OFS_CFG: rd[`TSCS_CFG_TSA] = q.time_slot_assigner;
				`TSCS_OFS_STAT: begin
					rd[`TSCS_STAT_TX_SYNC] = q.tx_st != tscs_pkg::TX_OFF && q.tx_st != tscs_pkg::TX_HUNT;
					rd[`TSCS_STAT_RX_SYNC] = q.rx_st == tscs_pkg::RX_ON;
					rd[`TSCS_STAT_STOPPED] = q.tx_stop;
					rd[`TSCS_STAT_UNDERRUN] = q.tx_un;
					rd[`TSCS_STAT_RX_BUSY] = q.rx_busy;
					rd[`TSCS_STAT_TX_PTR +: 8] = q.tx_ptr;
					rd[`TSCS_STAT_RX_PTR +: 8] = q.rx_ptr;
				end
				default: rd = 32'h0;
			endcase
		end
		d.rdata = rd;

		// ==========================================
		// Transmitter
		if (!ten_on) begin
			d.tx_st = tscs_pkg::TX_OFF;
			d.txd = 1'b1;
			d.tx_bit = 4'h0;
			d.tx_char = `TSCS_ONES;
			d.tx_stop = 1'b0;
		end else if (q.tx_st == tscs_pkg::TX_OFF) begin
			d.tx_st = tscs_pkg::TX_HUNT;
			d.tx_fs = 1'b0;
		end else begin
			if (q.sync2[SY_FS]) begin
				d.tx_fs = 1'b1;
			end
			// Pin sync; ignored once synced
			if (!q.time_slot_assigner && q.tx_st == tscs_pkg::TX_HUNT && rise && !q.sync2[SY_SYNC]) begin
				d.tx_st = tscs_pkg::TX_IDLE;
				d.tx_bit = 4'h0;
				d.tx_char = `TSCS_ONES;
			end
			if (fall && (!q.time_slot_assigner || q.sync2[SY_TXS])) begin
				// Slot start: first after frame sync, or resume after gap
				if (q.time_slot_assigner && !q.tx_slot_p && fifo_bus.valid &&
					(q.tx_st == tscs_pkg::TX_IDLE ||
					(q.tx_st == tscs_pkg::TX_HUNT && q.tx_fs))) begin
					cur = fifo_bus.rdata[15:0] & char_mask(char_length_field);
					d.tx_last = fifo_bus.rdata[16];
					nb = 4'h0;
					started = 1'b1;
					st_now = tscs_pkg::TX_DATA;
					d.tx_st = tscs_pkg::TX_DATA;
					pop = 1'b1;
				end
				if (st_now != tscs_pkg::TX_HUNT) begin
					d.txd = cur[bit_pos(nb, char_length_field, reverse_bit_order)];
					d.tx_char = cur;
					d.tx_bit = 4'(nb + 4'h1);
					if (nb == char_length_field) begin
						d.tx_bit = 4'h0;
						d.tx_char = `TSCS_ONES;
						if (fifo_bus.valid && !started && st_now != tscs_pkg::TX_HELD &&
							!(q.time_slot_assigner && st_now != tscs_pkg::TX_DATA)) begin
							d.tx_char = fifo_bus.rdata[15:0] & char_mask(char_length_field);
							d.tx_last = fifo_bus.rdata[16];
							d.tx_st = tscs_pkg::TX_DATA;
							pop = 1'b1;
						end else if (st_now == tscs_pkg::TX_DATA && q.tx_stop) begin
							d.tx_st = tscs_pkg::TX_HELD;
						end else if (st_now == tscs_pkg::TX_DATA && !q.tx_last) begin
							d.tx_st = tscs_pkg::TX_HELD;
							d.tx_err = 1'b1;
							d.tx_un = 1'b1;
							d.tx_ptr = ptr_next(q.tx_ptr);
						end else if (st_now == tscs_pkg::TX_DATA) begin
							d.tx_st = tscs_pkg::TX_IDLE;
						end
					end
				end
			end
			if (fall) begin
				d.tx_slot_p = q.sync2[SY_TXS];
			end
			if (c_hunt && !q.time_slot_assigner && q.tx_st != tscs_pkg::TX_HELD) begin
				d.tx_st = tscs_pkg::TX_HUNT;
			end
			if (c_stop) begin
				d.tx_stop = 1'b1;
			end
			if (c_restart) begin
				d.tx_stop = 1'b0;
				d.tx_un = d.tx_err;
				if (q.tx_st == tscs_pkg::TX_HELD) begin
					d.tx_st = tscs_pkg::TX_IDLE;
				end
			end
		end
		if (push && tx_char_last) begin
			d.tx_ptr = ptr_next(d.tx_ptr);
		end
		if (c_init_tx) begin
			d.tx_ptr = 8'h00;
			d.tx_stop = 1'b0;
			d.tx_un = d.tx_err;
		end
		cnt_next = 3'({1'b0, fifo_bus.count} + {2'b00, push} - {2'b00, pop});
		d.tx_ready = ten_on && d.tx_st != tscs_pkg::TX_OFF && d.tx_st != tscs_pkg::TX_HELD &&
			!d.tx_stop && cnt_next < 3'(`TSCS_TX_FIFO_DEPTH);

		// ==========================================
		// Receiver
		if (rx_pop) begin
			d.rx_full = 1'b0;
		end
		if (!ren_on) begin
			d.rx_st = tscs_pkg::RX_OFF;
			d.rx_bit = 4'h0;
			d.rx_acc = 16'h0;
		end else begin
			if (q.rx_st == tscs_pkg::RX_OFF) begin
				d.rx_st = tscs_pkg::RX_HUNT;
				d.rx_fs = 1'b0;
			end
			if (q.sync2[SY_FS]) begin
				d.rx_fs = 1'b1;
			end
			if (rise) begin
				if (q.rx_st == tscs_pkg::RX_HUNT) begin
					cap = q.time_slot_assigner ? (q.rx_fs && q.sync2[SY_RXS] && !q.rx_slot_p)
						: !q.sync2[SY_SYNC];
					if (cap) begin
						d.rx_st = tscs_pkg::RX_ON;
					end
				end else if (q.rx_st == tscs_pkg::RX_ON) begin
					cap = !q.time_slot_assigner || q.sync2[SY_RXS];
				end
				d.rx_slot_p = q.sync2[SY_RXS];
				if (cap) begin
					acc[bit_pos(q.rx_bit, char_length_field, reverse_bit_order)] = q.sync2[SY_RXD];
					if (q.rx_bit == char_length_field) begin
						d.rx_bit = 4'h0;
						d.rx_acc = 16'h0;
						if (q.rx_full && !rx_pop) begin
							d.rx_close = 1'b1;
							d.rx_ov = 1'b1;
							d.rx_ptr = ptr_next(q.rx_ptr);
						end
						d.rx_hold = acc;
						d.rx_full = 1'b1;
						d.rx_busy = 1'b1;
					end else begin
						d.rx_acc = acc;
						d.rx_bit = 4'(q.rx_bit + 4'h1);
					end
				end
			end
			if ((c_hunt || c_close) && q.rx_busy && !d.rx_close) begin
				d.rx_close = 1'b1;
				d.rx_ptr = ptr_next(q.rx_ptr);
				d.rx_busy = 1'b0;
			end
			if (c_hunt) begin
				d.rx_st = tscs_pkg::RX_HUNT;
				d.rx_fs = 1'b0;
				d.rx_bit = 4'h0;
				d.rx_acc = 16'h0;
			end
		end
		if (c_init_rx) begin
			d.rx_ptr = 8'h00;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
			q.mode <= `TSCS_MODE_RST;
			q.txd <= 1'b1;
			q.tx_char <= `TSCS_ONES;
		end else begin
			q <= d;
		end
	end

	// ==========================================
	// Outputs
	assign reg_rdata = q.rdata;
	assign txd = q.txd;
	assign tx_char_ready = q.tx_ready;
	assign tx_error_event = q.tx_err;
	assign tx_underrun_flag = q.tx_un;
	assign tx_descriptor_pointer = q.tx_ptr;
	assign rx_char_valid = q.rx_full;
	assign rx_char_data = q.rx_hold;
	assign rx_buf_close = q.rx_close;
	assign rx_buf_overrun = q.rx_ov;
	assign rx_descriptor_pointer = q.rx_ptr;

	// ==========================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence seq_hunt_cmd;
		c_hunt && ren_on;
	endsequence

	sequence seq_underrun;
		tx_error_event;
	endsequence

	a_idle_line_high: assert property (q.tx_st == tscs_pkg::TX_OFF |-> txd)
		else $error("line not high while transmitter off");
	a_txd_on_fall: assert property ($changed(txd) |-> $past(fall) || $past(!ten_on))
		else $error("transmit line changed away from a falling edge");
	a_held_no_fetch: assert property (q.tx_st == tscs_pkg::TX_HELD && !c_restart |=>
		!tx_char_ready) else $error("fetch while held");
	a_held_ptr_keep: assert property (q.tx_st == tscs_pkg::TX_HELD && !c_init_tx && !push
		|=> $stable(tx_descriptor_pointer)) else $error("pointer moved while held");
	a_underrun_held: assert property (seq_underrun |-> tx_underrun_flag &&
		q.tx_st == tscs_pkg::TX_HELD ##1 !tx_error_event) else $error("underrun handling wrong");
	a_hunt_drops: assert property (seq_hunt_cmd |=> q.rx_st == tscs_pkg::RX_HUNT)
		else $error("hunt did not drop receive sync");
	a_close_busy: assert property (rx_buf_close && !rx_buf_overrun |-> $past(q.rx_busy))
		else $error("close without active buffer");
	a_close_step: assert property (rx_buf_close |->
		rx_descriptor_pointer == ptr_next($past(rx_descriptor_pointer)))
		else $error("receive pointer did not advance on close");
	a_overrun_close: assert property (rx_buf_overrun |-> rx_buf_close && rx_char_valid)
		else $error("overrun without close");
	a_rx_upper_zero: assert property (rx_char_valid && $stable(char_length_field) |->
		(rx_char_data & ~char_mask(char_length_field)) == 16'h0) else $error("upper receive bits set");
	a_mode_reserved: assert property (q.mode[15] == 1'b0 && q.mode[10:9] == 2'b00 &&
		q.mode[7:6] == 2'b00) else $error("reserved mode bits set");
	a_off_unless_sm: assert property (!chan_on |=> q.tx_st == tscs_pkg::TX_OFF)
		else $error("transmitter active outside transparent mode");
endmodule : tscs_top

// ===== tscs_link_model.sv
`timescale 1ns/100ps
// ==========================================
// Far side of the serial link
module tscs_link_model (
	output logic sclk,
	output logic sync_n,
	output logic frame_sync,
	output logic tx_slot,
	output logic rx_slot,
	output logic rxd,
	input wire logic txd
);
	logic in_frame;

	initial begin
		sclk = 1'b0;
		sync_n = 1'b1;
		frame_sync = 1'b0;
		tx_slot = 1'b0;
		rx_slot = 1'b0;
		rxd = 1'b1;
		in_frame = 1'b0;
		#13;
		forever #40 sclk = ~sclk;
	end

	// Released data line toggles every bit
	always @(negedge sclk) begin
		if (!in_frame) begin
			rxd <= ~rxd;
		end
	end

	// ==========================================
	// One sync edge, rx stream out, tx stream in
	task automatic frame(input logic [31:0] rbits, output logic [47:0] tbits);
		in_frame = 1'b1;
		@(negedge sclk);
		sync_n = 1'b0;
		rxd = rbits[0];
		for (int i = 0; i < 48; i++) begin
			@(posedge sclk);
			tbits[i] = txd;
			@(negedge sclk);
			sync_n = (i < 1) ? 1'b0 : 1'b1;
			rxd = (i < 31) ? rbits[i + 1] : ~rxd;
		end
		@(posedge sclk);
		in_frame = 1'b0;
	endtask : frame

	// ==========================================
	// Frame sync, then one slot of n bits both ways
	task automatic slot_frame(input int n, input logic [15:0] rbits, output logic [15:0] tbits);
		tbits = 16'h0000;
		in_frame = 1'b1;
		@(negedge sclk);
		frame_sync = 1'b1;
		@(negedge sclk);
		frame_sync = 1'b0;
		tx_slot = 1'b1;
		rx_slot = 1'b1;
		rxd = rbits[0];
		for (int i = 0; i < n; i++) begin
			@(posedge sclk);
			tbits[i] = txd;
			@(negedge sclk);
			rxd = rbits[(i + 1) % 16];
		end
		tx_slot = 1'b0;
		rx_slot = 1'b0;
		in_frame = 1'b0;
	endtask : slot_frame
endmodule : tscs_link_model

// ===== tb.sv
`timescale 1ns/100ps
`include "tscs_cfg.svh"
`define TB_CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module tb;
	logic clk, rstn, reg_wr, reg_rd, sclk, sync_n, fsync, tslot, rslot, rxd, txd;
	logic tx_char_valid, tx_char_last, tx_char_ready, tx_error_event, tx_underrun_flag;
	logic rx_char_valid, rx_char_ready, rx_buf_close, rx_buf_overrun;
	logic [7:0] reg_addr, tx_descriptor_pointer, rx_descriptor_pointer, exp_rxp;
	logic [31:0] reg_wdata, reg_rdata;
	logic [15:0] tx_char_data, rx_char_data;
	logic [15:0] rxq[$];
	int fails, n_compared, cyc, closes, ovs, errs, seed;

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	tscs_top #(.NUM_BD(8'h08)) dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.serial_bit_clock(sclk), .ext_sync_pin(sync_n), .frame_sync(fsync), .tx_slot(tslot),
		.rx_slot(rslot), .rxd(rxd), .txd(txd), .tx_char_valid(tx_char_valid),
		.tx_char_data(tx_char_data), .tx_char_last(tx_char_last), .tx_char_ready(tx_char_ready),
		.tx_error_event(tx_error_event), .tx_underrun_flag(tx_underrun_flag),
		.tx_descriptor_pointer(tx_descriptor_pointer), .rx_char_valid(rx_char_valid),
		.rx_char_data(rx_char_data), .rx_char_ready(rx_char_ready), .rx_buf_close(rx_buf_close),
		.rx_buf_overrun(rx_buf_overrun), .rx_descriptor_pointer(rx_descriptor_pointer));

	tscs_link_model m (.sclk(sclk), .sync_n(sync_n), .frame_sync(fsync), .tx_slot(tslot),
		.rx_slot(rslot), .rxd(rxd), .txd(txd));

	task automatic finish_test();
		if (fails == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : finish_test

	// ==========================================
	// Monitor and watchdog
	always @(posedge clk) begin
		cyc++;
		if (cyc == 50000) begin
			fails++;
			finish_test();
		end
		if (rx_char_valid === 1'b1 && rx_char_ready === 1'b1) begin
			rxq.push_back(rx_char_data);
		end
		if (rx_buf_close === 1'b1) begin
			closes++;
			exp_rxp = (exp_rxp == 8'h07) ? 8'h00 : exp_rxp + 8'h01;
		end
		if (rx_buf_overrun === 1'b1) begin
			ovs++;
		end
		if (tx_error_event === 1'b1) begin
			errs++;
		end
	end

	// ==========================================
	// Bus and stream tasks
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		v = reg_rdata;
	endtask : rd

	task automatic cmd(input int b);
		wr(`TSCS_OFS_CMD, 32'h1 << b);
		repeat (4) @(posedge clk);
	endtask : cmd

	task automatic push(input logic [15:0] d, input logic l);
		tx_char_valid <= 1'b1;
		tx_char_data <= d;
		tx_char_last <= l;
		@(posedge clk);
		while (tx_char_ready !== 1'b1) @(posedge clk);
		tx_char_valid <= 1'b0;
		@(posedge clk);
	endtask : push

	task automatic wait_cnt(ref int c, input int v);
		for (int i = 0; i < 4000 && c <= v; i++) @(posedge clk);
	endtask : wait_cnt

	// Bit i of the result is the i-th bit on the line
	function automatic logic [15:0] line_order(input logic [15:0] d, input int char_length_field, input logic rev);
		logic [15:0] v;
		v = 16'h0000;
		for (int i = 0; i <= char_length_field; i++) v[i] = rev ? d[char_length_field - i] : d[i];
		return v;
	endfunction : line_order

	// ==========================================
	// Main sequence
	initial begin
		logic [31:0] v, r;
		logic [47:0] tb_bits;
		logic [15:0] d, mode, tsb;
		logic [3:0] char_length_field;
		logic rev;
		int k;
		seed = 92287;
		rstn = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		tx_char_valid = 1'b0;
		tx_char_data = 16'h0000;
		tx_char_last = 1'b0;
		rx_char_ready = 1'b1;
		exp_rxp = 8'h00;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd(`TSCS_OFS_MODE, v);
		`TB_CHK(v, 32'h0)
		wr(`TSCS_OFS_MODE, 32'h0000ffff);
		rd(`TSCS_OFS_MODE, v);
		`TB_CHK(v, {16'h0000, `TSCS_MODE_WMASK})
		rd(8'h40, v);
		`TB_CHK(v, 32'h0)
		wr(`TSCS_OFS_MODE, 32'h0);
		for (int it = 0; it < 2; it++) begin
			rev = it[0];
			char_length_field = rev ? 4'h7 : 4'h4;
			mode = {1'b0, char_length_field, 2'b00, rev, 2'b00, `TSCS_SM_TRANSPARENT, 4'h3};
			wr(`TSCS_OFS_MODE, {16'h0000, mode});
			`TB_CHK(txd, 1'b1)
			k = closes;
			cmd(`TSCS_CMD_CLOSE_RX);
			`TB_CHK(closes, k)
			`TB_CHK(rx_descriptor_pointer, 8'h00)
			d = 16'($random(seed));
			d[rev ? char_length_field : 4'h0] = 1'b0;
			push(d, 1'b0);
			r = $random(seed);
			rxq.delete();
			m.frame(r, tb_bits);
			k = 1;
			while (k < 40 && tb_bits[k] === 1'b1) k++;
			`TB_CHK(k - 1, int'(char_length_field) + 1)
			v = 32'h0;
			for (int i = 0; i <= char_length_field; i++) v[i] = tb_bits[k + i];
			`TB_CHK(v[15:0], line_order(d, char_length_field, rev))
			wait_cnt(errs, it);
			`TB_CHK(errs, it + 1)
			`TB_CHK(tx_underrun_flag, 1'b1)
			`TB_CHK(tx_descriptor_pointer, 8'h01)
			`TB_CHK(rxq[0], line_order(r[15:0], char_length_field, rev))
			rd(`TSCS_OFS_STAT, v);
			`TB_CHK(v[1:0], 2'b11)
			cmd(`TSCS_CMD_RESTART);
			`TB_CHK(tx_underrun_flag, 1'b0)
			cmd(`TSCS_CMD_STOP);
			rd(`TSCS_OFS_STAT, v);
			`TB_CHK(v[`TSCS_STAT_STOPPED], 1'b1)
			`TB_CHK(tx_char_ready, 1'b0)
			`TB_CHK(tx_descriptor_pointer, 8'h01)
			cmd(`TSCS_CMD_RESTART);
			rd(`TSCS_OFS_STAT, v);
			`TB_CHK(v[`TSCS_STAT_STOPPED], 1'b0)
			k = closes;
			cmd(`TSCS_CMD_CLOSE_RX);
			`TB_CHK(closes, k + 1)
			rx_char_ready <= 1'b0;
			k = ovs;
			wait_cnt(ovs, k);
			rx_char_ready <= 1'b1;
			`TB_CHK(ovs, k + 1)
			repeat (3) @(posedge clk);
			@(negedge clk);
			`TB_CHK(rx_descriptor_pointer, exp_rxp)
			k = rxq.size();
			repeat (600) @(posedge clk);
			`TB_CHK(rxq.size() > k, 1'b1)
			k = closes;
			cmd(`TSCS_CMD_HUNT);
			rd(`TSCS_OFS_STAT, v);
			`TB_CHK(v[`TSCS_STAT_RX_SYNC], 1'b0)
			`TB_CHK(closes, k + 1)
			wr(`TSCS_OFS_MODE, {16'h0000, mode & 16'hfffc});
			repeat (4) @(posedge sclk);
			@(posedge clk);
			cmd(`TSCS_CMD_INIT_TX);
			cmd(`TSCS_CMD_INIT_RX);
			exp_rxp = 8'h00;
			`TB_CHK(tx_descriptor_pointer, 8'h00)
			`TB_CHK(rx_descriptor_pointer, 8'h00)
		end
		// ==========================================
		// Time-slot mode: one slot per frame, both ways
		wr(`TSCS_OFS_CFG, 32'h1);
		mode = {1'b0, 4'h7, 2'b00, 1'b0, 2'b00, `TSCS_SM_TRANSPARENT, 4'h3};
		wr(`TSCS_OFS_MODE, {16'h0000, mode});
		rxq.delete();
		for (int it = 0; it < 2; it++) begin
			d = 16'($random(seed));
			push(d, 1'b1);
			r = $random(seed);
			m.slot_frame(8, r[15:0], tsb);
			`TB_CHK(tsb, line_order(d, 7, 1'b0))
			repeat (400) @(posedge clk);
			`TB_CHK(rxq.size(), it + 1)
			`TB_CHK(rxq[it], line_order(r[15:0], 7, 1'b0))
			rd(`TSCS_OFS_STAT, v);
			`TB_CHK(v[`TSCS_STAT_RX_SYNC], 1'b1)
			if (it == 0) begin
				k = closes;
				cmd(`TSCS_CMD_HUNT);
				`TB_CHK(closes, k + 1)
				rd(`TSCS_OFS_STAT, v);
				`TB_CHK(v[`TSCS_STAT_RX_SYNC], 1'b0)
			end
		end
		finish_test();
	end
endmodule : tb
